//--- sfe_pkg.sv
// Constants for the floating-point micro-op event selection block.
// Assumes a 32-bit classic Wishbone slave.
package sfe_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] SFE_OFS_SEL_A = 8'h00; // Event select a
	localparam logic [7:0] SFE_OFS_SEL_B = 8'h04; // Event select b
	localparam logic [7:0] SFE_OFS_CFG0 = 8'h08; // First counter config, word steps
	localparam logic [7:0] SFE_OFS_CNT0 = 8'h18; // First counter value, word steps
	localparam logic [7:0] SFE_OFS_UOP = 8'h28; // Last micro-op status
	// ==========================================
	// Field positions
	localparam int SFE_SEL_LSB = 25; // Event select field [31:25]
	localparam int SFE_SEL_MSB = 31;
	localparam int SFE_MASK_LSB = 9; // Event mask field [24:9]
	localparam int SFE_ALL_BIT = 15; // Mask bit "all", within mask field
	localparam int SFE_CSEL_LSB = 13; // Counter config select [15:13]
	localparam int SFE_CSEL_MSB = 15;
	// ==========================================
	// Event codes
	localparam logic [6:0] SFE_EV_PACKED_SINGLE = 7'h08;
	localparam logic [6:0] SFE_EV_PACKED_DOUBLE = 7'h0c;
	localparam logic [6:0] SFE_EV_SCALAR_SINGLE = 7'h0a;
	localparam logic [6:0] SFE_EV_SCALAR_DOUBLE = 7'h0e;
	localparam logic [6:0] SFE_EV_INT_SIMD64 = 7'h02;
	localparam logic [2:0] SFE_CSEL_FP = 3'h1; // Counter select for these events
	// ==========================================
	// Micro-op class bit positions on the dispatch vectors
	localparam int SFE_UC_PS = 0; // Packed single
	localparam int SFE_UC_PD = 1; // Packed double
	localparam int SFE_UC_SS = 2; // Scalar single
	localparam int SFE_UC_SD = 3; // Scalar double
	localparam int SFE_UC_I64 = 4; // 64-bit integer SIMD
	localparam int SFE_UC_N = 5;
	localparam logic [31:0] SFE_RST_WORD = 32'h0000_0000;
endpackage

//--- sfe_match.sv
// Per-counter event qualifier: code match, mask check, lane count.
// Assumes select and config values are stable register outputs.
`timescale 1ns/1ps
module sfe_match #(
	parameter int LANES = 4 // Micro-ops dispatched per cycle
) (
	input wire logic [31:0] i_event_selection_ctrl_reg_word, // Event selection word
	input wire logic [31:0] i_cfg_word, // Counter config word
	input wire logic [LANES*sfe_pkg::SFE_UC_N-1:0] i_uop_class, // Class bits per lane
	input wire logic [LANES-1:0] i_uop_mem, // Lane operand from memory
	input wire logic [LANES-1:0] i_uop_rep_move, // Lane inside repeated string move
	output logic [$clog2(LANES+1)-1:0] o_incr // Qualifying micro-ops this cycle
);
	// ==========================================
	// Field decode
	wire [6:0] sel_code = i_event_selection_ctrl_reg_word[sfe_pkg::SFE_SEL_MSB:sfe_pkg::SFE_SEL_LSB];
	wire all_bit = i_event_selection_ctrl_reg_word[sfe_pkg::SFE_MASK_LSB + sfe_pkg::SFE_ALL_BIT];
	wire cfg_ok = i_cfg_word[sfe_pkg::SFE_CSEL_MSB:sfe_pkg::SFE_CSEL_LSB] == sfe_pkg::SFE_CSEL_FP;
	wire [sfe_pkg::SFE_UC_N-1:0] code_hit;
	assign code_hit[sfe_pkg::SFE_UC_PS] = sel_code == sfe_pkg::SFE_EV_PACKED_SINGLE;
	assign code_hit[sfe_pkg::SFE_UC_PD] = sel_code == sfe_pkg::SFE_EV_PACKED_DOUBLE;
	assign code_hit[sfe_pkg::SFE_UC_SS] = sel_code == sfe_pkg::SFE_EV_SCALAR_SINGLE;
	assign code_hit[sfe_pkg::SFE_UC_SD] = sel_code == sfe_pkg::SFE_EV_SCALAR_DOUBLE;
	assign code_hit[sfe_pkg::SFE_UC_I64] = sel_code == sfe_pkg::SFE_EV_INT_SIMD64;
	// Nothing counts without the mask bit or a valid select
	wire armed = all_bit & cfg_ok;
	// ==========================================
	// Per-lane qualify
	wire [LANES-1:0] lane_hit;
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			wire [sfe_pkg::SFE_UC_N-1:0] cls = i_uop_class[g*sfe_pkg::SFE_UC_N +: sfe_pkg::SFE_UC_N];
			// Repeated string moves carry packed memory micro-ops too
			wire rep_ps = i_uop_rep_move[g] & i_uop_mem[g] & code_hit[sfe_pkg::SFE_UC_PS];
			// Memory or register operand both count for 64-bit integer SIMD
			assign lane_hit[g] = armed & (|(cls & code_hit) | rep_ps);
		end
	endgenerate
	// Population count: every lane counts, not one per instruction
	always_comb begin
		o_incr = '0;
		for (int i = 0; i < LANES; i++) begin
			o_incr = o_incr + {{($clog2(LANES+1)-1){1'b0}}, lane_hit[i]};
		end
	end
endmodule

//--- sfe_event_select.sv
// Top of the floating-point micro-op event selection block.
// Assumes core clock at 20 MHz, classic Wishbone master, dispatch inputs
// synchronous to i_sys_clk.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module sfe_event_select #(
	parameter int LANES = 4, // Micro-ops dispatched per cycle
	parameter int CNT_W = 32 // Counter width, at most 32
) (
	input wire logic i_sys_clk, // Core clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_wb_cyc, // Wishbone cycle
	input wire logic i_wb_stb, // Wishbone strobe
	input wire logic i_wb_we, // Write enable
	input wire logic [7:0] i_wb_adr, // Byte address
	input wire logic [3:0] i_wb_sel, // Byte selects
	input wire logic [31:0] i_wb_dat, // Write data
	output logic [31:0] o_wb_dat, // Read data
	output logic o_wb_ack, // Acknowledge
	input wire logic [LANES*sfe_pkg::SFE_UC_N-1:0] i_uop_class, // Class bits per lane
	input wire logic [LANES-1:0] i_uop_mem, // Memory operand per lane
	input wire logic [LANES-1:0] i_uop_rep_move, // Repeated string move per lane
	output logic [CNT_W-1:0] o_cnt8, // Counter 8
	output logic [CNT_W-1:0] o_cnt9, // Counter 9
	output logic [CNT_W-1:0] o_cnt10, // Counter 10
	output logic [CNT_W-1:0] o_cnt11 // Counter 11
);
	localparam int IW = $clog2(LANES+1);
	// ==========================================
	// Storage
	logic [31:0] fp_event_select_reg_a; // Feeds counters 8 and 9
	logic [31:0] fp_event_select_reg_b; // Feeds counters 10 and 11
	logic [31:0] counter_config_ctrl_reg [4]; // One per counter
	logic [CNT_W-1:0] cnt_reg [4]; // Counters 8..11
	logic [sfe_pkg::SFE_UC_N-1:0] uop_seen_reg; // Classes seen last cycle
	logic [31:0] rdat_reg; // Read data
	logic ack_reg; // Ack flop
	wire [IW-1:0] incr [4];
	// ==========================================
	// Bus decode
	wire req = i_wb_cyc & i_wb_stb & ~ack_reg; // Ack drops one cycle after
	wire wr = req & i_wb_we;
	wire [31:0] bmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	wire hit_a = i_wb_adr == sfe_pkg::SFE_OFS_SEL_A;
	wire hit_b = i_wb_adr == sfe_pkg::SFE_OFS_SEL_B;
	wire hit_u = i_wb_adr == sfe_pkg::SFE_OFS_UOP;
	wire [sfe_pkg::SFE_UC_N-1:0] seen_now;
	// ==========================================
	// Counters, config and qualifiers per counter
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_cnt
			wire hit_c = i_wb_adr == sfe_pkg::SFE_OFS_CFG0 + 8'(4*g);
			wire hit_n = i_wb_adr == sfe_pkg::SFE_OFS_CNT0 + 8'(4*g);
			// Counters 8,9 take select a; 10,11 take select b
			wire [31:0] event_selection_ctrl_reg = (g < 2) ? fp_event_select_reg_a : fp_event_select_reg_b;
			sfe_match #(.LANES(LANES)) u_match (
				.i_event_selection_ctrl_reg_word(event_selection_ctrl_reg),
				.i_cfg_word(counter_config_ctrl_reg[g]),
				.i_uop_class(i_uop_class),
				.i_uop_mem(i_uop_mem),
				.i_uop_rep_move(i_uop_rep_move),
				.o_incr(incr[g])
			);
			// Config register, byte-lane writes
			always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					counter_config_ctrl_reg[g] <= sfe_pkg::SFE_RST_WORD;
				end else if (wr && hit_c) begin
					counter_config_ctrl_reg[g] <= (counter_config_ctrl_reg[g] & ~bmask) | (i_wb_dat & bmask);
				end
			end
			// Counter: software write wins over increment that cycle
			always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					cnt_reg[g] <= '0;
				end else if (wr && hit_n) begin
					cnt_reg[g] <= CNT_W'(i_wb_dat);
				end else begin
					cnt_reg[g] <= cnt_reg[g] + CNT_W'(incr[g]);
				end
			end
		end
	endgenerate
	// Class activity summary, for software sanity checks
	generate
		for (g = 0; g < sfe_pkg::SFE_UC_N; g++) begin : g_seen
			wire [LANES-1:0] col;
			for (genvar l = 0; l < LANES; l++) begin : g_l
				assign col[l] = i_uop_class[l*sfe_pkg::SFE_UC_N + g];
			end
			assign seen_now[g] = |col;
		end
	endgenerate
	// ==========================================
	// Read mux, unmapped reads return zero
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0000_0000;
		if (hit_a) begin
			rmux = fp_event_select_reg_a;
		end else if (hit_b) begin
			rmux = fp_event_select_reg_b;
		end else if (hit_u) begin
			rmux = 32'(uop_seen_reg);
		end
		for (int i = 0; i < 4; i++) begin
			if (i_wb_adr == sfe_pkg::SFE_OFS_CFG0 + 8'(4*i)) begin
				rmux = counter_config_ctrl_reg[i];
			end
			if (i_wb_adr == sfe_pkg::SFE_OFS_CNT0 + 8'(4*i)) begin
				rmux = 32'(cnt_reg[i]);
			end
		end
	end
	// ==========================================
	// Select registers and bus handshake
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fp_event_select_reg_a <= sfe_pkg::SFE_RST_WORD;
			fp_event_select_reg_b <= sfe_pkg::SFE_RST_WORD;
			ack_reg <= 1'b0;
			rdat_reg <= sfe_pkg::SFE_RST_WORD;
			uop_seen_reg <= '0;
		end else begin
			ack_reg <= req; // One wait state, every address answered
			rdat_reg <= req ? rmux : rdat_reg;
			uop_seen_reg <= seen_now;
			if (wr && hit_a) begin
				fp_event_select_reg_a <= (fp_event_select_reg_a & ~bmask) | (i_wb_dat & bmask);
			end
			if (wr && hit_b) begin
				fp_event_select_reg_b <= (fp_event_select_reg_b & ~bmask) | (i_wb_dat & bmask);
			end
		end
	end
	// ==========================================
	// Outputs straight from flops
	assign o_wb_ack = ack_reg;
	assign o_wb_dat = rdat_reg;
	assign o_cnt8 = cnt_reg[0];
	assign o_cnt9 = cnt_reg[1];
	assign o_cnt10 = cnt_reg[2];
	assign o_cnt11 = cnt_reg[3];
endmodule

//--- sfe_event_select_checker.sv
// Port-level checker for the micro-op event selection block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module sfe_event_select_checker #(
	parameter int LANES = 4, // Lanes per cycle
	parameter int CNT_W = 32 // Counter width
) (
	input wire logic i_sys_clk, // Clock
	input wire logic i_rst_b, // Reset
	input wire logic i_wb_cyc, // Cycle
	input wire logic i_wb_stb, // Strobe
	input wire logic i_wb_we, // Write
	input wire logic o_wb_ack, // Ack
	input wire logic [LANES*sfe_pkg::SFE_UC_N-1:0] i_uop_class, // Classes
	input wire logic [LANES-1:0] i_uop_mem, // Memory
	input wire logic [LANES-1:0] i_uop_rep_move, // String move
	input wire logic [CNT_W-1:0] o_cnt8, // Counter 8
	input wire logic [CNT_W-1:0] o_cnt9, // Counter 9
	input wire logic [CNT_W-1:0] o_cnt10, // Counter 10
	input wire logic [CNT_W-1:0] o_cnt11 // Counter 11
);
	// ==========================================
	// Helpers
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	wire logic wr_req = i_wb_cyc && i_wb_stb && i_wb_we; // Counter write may land
	// No micro-op at all and no write: nothing may move
	wire logic quiet = (i_uop_class == '0) && ((i_uop_mem & i_uop_rep_move) == '0) && !wr_req;
	// ==========================================
	// Assertions
	AST_ACK_PULSE:
		assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
	AST_ACK_ANSWER:
		assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
	AST_HOLD8:
		assert property (quiet |=> $stable(o_cnt8)) else $error("counter 8 moved idle");
	AST_HOLD9:
		assert property (quiet |=> $stable(o_cnt9)) else $error("counter 9 moved idle");
	AST_HOLD10:
		assert property (quiet |=> $stable(o_cnt10)) else $error("counter 10 moved idle");
	AST_HOLD11:
		assert property (quiet |=> $stable(o_cnt11)) else $error("counter 11 moved idle");
	AST_STEP8:
		assert property (!wr_req |=> (o_cnt8 - $past(o_cnt8)) <= LANES) else $error("step 8");
	AST_STEP10:
		assert property (!wr_req |=> (o_cnt10 - $past(o_cnt10)) <= LANES) else $error("step 10");
	cover property (o_wb_ack);
	cover property ($changed(o_cnt8));
	cover property ($changed(o_cnt10));
endmodule

//--- sfe_uop_source.sv
// Dispatch-side model: random micro-op bursts, tallied per class.
// Assumes the caller seeds the random generator.
`timescale 1ns/1ps
module sfe_uop_source (
	input wire logic i_sys_clk, // Clock
	output logic [19:0] o_uop_class, // Four lanes of class bits
	output logic [3:0] o_uop_mem, // Memory operand
	output logic [3:0] o_uop_rep_move // String move
);
	int tally[5]; // Lanes dispatched per class in the last burst
	initial begin
		o_uop_class = '0;
		o_uop_mem = '0;
		o_uop_rep_move = '0;
	end
	// ==========================================
	// Burst of n busy cycles, then idle lanes
	task automatic burst(input int n);
		logic [19:0] c;
		logic [3:0] m;
		logic [3:0] r;
		tally = '{default: 0};
		for (int i = 0; i < n; i++) begin
			c = $urandom;
			m = $urandom;
			r = $urandom;
			for (int l = 0; l < 4; l++) begin
				for (int k = 0; k < 5; k++) begin
					// String-move memory lanes also count as packed single
					tally[k] += (c[l*5+k] || (k == 0 && m[l] && r[l])) ? 1 : 0;
				end
			end
			@(posedge i_sys_clk);
			o_uop_class <= c;
			o_uop_mem <= m;
			o_uop_rep_move <= r;
		end
		@(posedge i_sys_clk);
		o_uop_class <= '0;
		o_uop_mem <= '0;
		o_uop_rep_move <= '0;
	endtask
endmodule

//--- sfe_event_select_test.sv
// Self-checking bench: bus reads queued, compared on ack.
// Assumes a 20 MHz clock and bursts from the dispatch model.
`timescale 1ns/1ps
module sfe_event_select_test;
	logic clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = '0;
	logic [31:0] dat = '0, rdat;
	logic [3:0] sel = 4'hf;
	logic ack;
	logic [19:0] ucls;
	logic [3:0] umem, urep;
	logic [31:0] c8, c9, c10, c11;
	logic [31:0] q[$]; // Expected read data
	logic [6:0] codes[5];
	int n_mismatch = 0, comparisons = 0, cycles = 0;
	sfe_event_select u_sfe_event_select (.i_sys_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .i_uop_class(ucls), .i_uop_mem(umem),
		.i_uop_rep_move(urep), .o_cnt8(c8), .o_cnt9(c9), .o_cnt10(c10), .o_cnt11(c11));
	sfe_uop_source u_sfe_uop_source (.i_sys_clk(clk), .o_uop_class(ucls), .o_uop_mem(umem),
		.o_uop_rep_move(urep));
	initial begin
		forever #25 clk = ~clk;
	end
	// ==========================================
	// Timeout and checking
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			stop_test();
		end
	end
	// Read data is settled by the falling edge
	always @(negedge clk) begin
		if (ack === 1'b1 && we === 1'b0) chk("o_wb_dat", rdat, q.pop_front());
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s, expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ==========================================
	// Classic single cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		wb(1'b0, a, '0);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		int j;
		void'($urandom(32'h06cb));
		codes = '{sfe_pkg::SFE_EV_PACKED_SINGLE, sfe_pkg::SFE_EV_PACKED_DOUBLE,
			sfe_pkg::SFE_EV_SCALAR_SINGLE, sfe_pkg::SFE_EV_SCALAR_DOUBLE,
			sfe_pkg::SFE_EV_INT_SIMD64};
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		// Counter 11 gets a wrong select and must stay still
		for (int k = 0; k < 3; k++) wb(1'b1, 8'h08 + 8'(4 * k), 32'h0000_2000);
		wb(1'b1, 8'h14, 32'h0000_4000);
		for (int i = 0; i < 6; i++) begin
			j = (i + 1) % 5;
			// Last pass: mask bit other than 15 only
			wb(1'b1, 8'h00, {codes[i % 5], (i < 5), 24'h80_0000});
			wb(1'b1, 8'h04, {codes[j], 1'b1, 24'h0});
			for (int k = 0; k < 4; k++) wb(1'b1, 8'h18 + 8'(4 * k), '0);
			u_sfe_uop_source.burst(3 + i);
			repeat (2) @(posedge clk);
			rd(8'h18, (i < 5) ? u_sfe_uop_source.tally[i] : 0);
			chk("o_cnt9", c9, (i < 5) ? u_sfe_uop_source.tally[i] : 0);
			rd(8'h20, u_sfe_uop_source.tally[j]);
			chk("o_cnt10", c10, u_sfe_uop_source.tally[j]);
			rd(8'h24, '0);
			chk("o_cnt11", c11, '0);
			chk("o_cnt8", c8, (i < 5) ? u_sfe_uop_source.tally[i] : 0);
			rd(8'h00, {codes[i % 5], (i < 5), 24'h80_0000});
			rd(8'h28, '0);
		end
		rd(8'h3c, '0);
		repeat (3) @(posedge clk);
		stop_test();
	end
endmodule
bind sfe_event_select sfe_event_select_checker #(.LANES(LANES), .CNT_W(CNT_W)) u_chk (
	.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we), .o_wb_ack(o_wb_ack), .i_uop_class(i_uop_class), .i_uop_mem(i_uop_mem),
	.i_uop_rep_move(i_uop_rep_move), .o_cnt8(o_cnt8), .o_cnt9(o_cnt9), .o_cnt10(o_cnt10),
	.o_cnt11(o_cnt11));
